/* core/mgmt_device.sv */
`timescale 1ns/1ps
module mgmt_device (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Management link
   mgmt_if.device           mif,
   // Straps
   input  wire logic        broadcast_disable_strap,
   input  wire logic [2:0]  unique_address_strap,
   // Interrupt
   input  wire logic [7:0]  int_event,
   output logic             interrupt_request_out,
   // Crossover
   input  wire logic        auto_mdix_detect,
   output logic             pair_swap,
   // Loopback and power
   input  wire logic        link_100fd,
   output logic             local_loopback,
   output logic             remote_loopback,
   output logic             power_down,
   // Cable diagnostic
   input  wire logic [14:0] cable_diagnostic_result,
   output logic             cable_diagnostic_start
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detect
   logic [5:0]  pins_s;
   logic        mdc_s;
   logic        mdio_s;
   logic        mdc_prev_ff;
   logic        mdc_rise;

   sync2 #(.WIDTH(6)) u_sync (
      .clk (ref_clk),
      .d   ({mif.mdc, mif.mdio, broadcast_disable_strap, unique_address_strap}),
      .q   (pins_s)
   );

   assign mdc_s    = pins_s[5];
   assign mdio_s   = pins_s[4];
   assign mdc_rise = mdc_s & ~mdc_prev_ff;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mdc_prev_ff <= 1'b1;
      end else begin
         mdc_prev_ff <= mdc_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Straps, sampled while reset is low
   logic [2:0]  own_addr_ff;
   logic        strap_bcast_off_ff;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         own_addr_ff        <= pins_s[2:0];
         strap_bcast_off_ff <= pins_s[3];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [15:0] basic_ctrl_ff;
   logic        bcast_off_reg_ff;
   logic [7:0]  int_en_ff;
   logic [7:0]  int_st_ff;
   logic        mdix_sel_ff;
   logic        auto_off_ff;
   logic        int_level_ff;
   logic        remote_loop_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Frame decoder
   mgmt_pkg::dev_state_t state_ff;
   logic [5:0]  ones_ff;
   logic [3:0]  cnt_ff;
   logic [11:0] cmd_ff;
   logic [15:0] data_ff;
   logic        hit_ff;
   logic        rd_ff;
   logic        drv_oe_ff;
   logic        drv_out_ff;
   logic [11:0] nxt_cmd;
   logic        bcast_en;
   logic        nxt_hit;
   logic        wr_fire;
   logic        rd_fire;
   logic [15:0] wr_data;
   logic [4:0]  reg_addr;
   logic [15:0] rd_value;
   logic        sw_reset;

   assign nxt_cmd  = {cmd_ff[10:0], mdio_s};
   assign bcast_en = ~strap_bcast_off_ff & ~bcast_off_reg_ff;
   // Address 0 stays a plain match against the strap when broadcast is off
   assign nxt_hit  = (nxt_cmd[9:8] == 2'h0)
                   && ((nxt_cmd[7:5] == own_addr_ff)
                       || ((nxt_cmd[7:5] == 3'h0) && bcast_en))
                   && ((nxt_cmd[11:10] == mgmt_pkg::OP_READ)
                       || (nxt_cmd[11:10] == mgmt_pkg::OP_WRITE));
   assign reg_addr = cmd_ff[4:0];
   assign wr_data  = {data_ff[14:0], mdio_s};
   assign wr_fire  = mdc_rise && (state_ff == mgmt_pkg::ST_DATA) && (cnt_ff == 4'hF)
                   && hit_ff && !rd_ff;
   assign rd_fire  = mdc_rise && (state_ff == mgmt_pkg::ST_TA) && (cnt_ff == 4'h1)
                   && hit_ff && rd_ff;
   assign sw_reset = wr_fire && (reg_addr == mgmt_pkg::REG_BASIC_CTRL)
                   && wr_data[mgmt_pkg::BC_SOFT_RESET];

   // Unlisted locations read zero and ignore writes
   always_comb begin
      rd_value = 16'h0000;
      case (reg_addr)
         mgmt_pkg::REG_BASIC_CTRL:    rd_value = basic_ctrl_ff;
         mgmt_pkg::REG_OP_MODE:       rd_value[mgmt_pkg::OM_BCAST_OFF] = bcast_off_reg_ff;
         mgmt_pkg::REG_INT_CTRL_STAT: rd_value = {int_en_ff, int_st_ff};
         mgmt_pkg::REG_CABLE_DIAG:    rd_value = {1'b0, cable_diagnostic_result};
         mgmt_pkg::REG_PHY_CTRL2: begin
            rd_value[mgmt_pkg::PC2_MDIX_SEL]    = mdix_sel_ff;
            rd_value[mgmt_pkg::PC2_AUTO_OFF]    = auto_off_ff;
            rd_value[mgmt_pkg::PC2_INT_LEVEL]   = int_level_ff;
            rd_value[mgmt_pkg::PC2_REMOTE_LOOP] = remote_loop_ff;
         end
         default:                     rd_value = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff   <= mgmt_pkg::ST_IDLE;
         ones_ff    <= 6'h00;
         cnt_ff     <= 4'h0;
         cmd_ff     <= 12'h000;
         data_ff    <= 16'h0000;
         hit_ff     <= 1'b0;
         rd_ff      <= 1'b0;
         drv_oe_ff  <= 1'b0;
         drv_out_ff <= 1'b1;
      end else if (mdc_rise) begin
         case (state_ff)
            mgmt_pkg::ST_IDLE: begin
               if (mdio_s) begin
                  if (ones_ff != 6'(mgmt_pkg::PREAMBLE_BITS)) begin
                     ones_ff <= ones_ff + 6'h01;
                  end
               end else begin
                  // First half of the start pattern
                  if (ones_ff == 6'(mgmt_pkg::PREAMBLE_BITS)) begin
                     state_ff <= mgmt_pkg::ST_START;
                  end
                  ones_ff <= 6'h00;
               end
            end
            mgmt_pkg::ST_START: begin
               cnt_ff   <= 4'h0;
               state_ff <= mdio_s ? mgmt_pkg::ST_CMD : mgmt_pkg::ST_IDLE;
            end
            mgmt_pkg::ST_CMD: begin
               cmd_ff <= nxt_cmd;
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == 4'(mgmt_pkg::CMD_BITS - 1)) begin
                  hit_ff   <= nxt_hit;
                  rd_ff    <= (nxt_cmd[11:10] == mgmt_pkg::OP_READ);
                  cnt_ff   <= 4'h0;
                  state_ff <= mgmt_pkg::ST_TA;
               end
            end
            mgmt_pkg::ST_TA: begin
               if (cnt_ff == 4'h0) begin
                  cnt_ff <= 4'h1;
                  if (hit_ff && rd_ff) begin
                     drv_oe_ff  <= 1'b1;
                     drv_out_ff <= 1'b0;
                  end
               end else begin
                  cnt_ff   <= 4'h0;
                  state_ff <= mgmt_pkg::ST_DATA;
                  if (rd_fire) begin
                     data_ff    <= rd_value;
                     drv_out_ff <= rd_value[15];
                  end
               end
            end
            mgmt_pkg::ST_DATA: begin
               cnt_ff <= cnt_ff + 4'h1;
               if (rd_ff) begin
                  drv_out_ff <= data_ff[14];
                  data_ff    <= {data_ff[14:0], 1'b0};
               end else begin
                  data_ff    <= wr_data;
               end
               if (cnt_ff == 4'(mgmt_pkg::DATA_BITS - 1)) begin
                  drv_oe_ff  <= 1'b0;
                  drv_out_ff <= 1'b1;
                  ones_ff    <= 6'h00;
                  state_ff   <= mgmt_pkg::ST_IDLE;
               end
            end
            default: begin
               drv_oe_ff <= 1'b0;
               state_ff  <= mgmt_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign mif.mdio_d_out = drv_out_ff;
   assign mif.mdio_d_oe  = drv_oe_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge ref_clk) begin
      if (!rst_n || sw_reset) begin
         basic_ctrl_ff    <= mgmt_pkg::BASIC_CTRL_RST;
         bcast_off_reg_ff <= 1'b0;
         int_en_ff        <= 8'h00;
         mdix_sel_ff      <= mgmt_pkg::PHY_CTRL2_RST[mgmt_pkg::PC2_MDIX_SEL];
         auto_off_ff      <= mgmt_pkg::PHY_CTRL2_RST[mgmt_pkg::PC2_AUTO_OFF];
         int_level_ff     <= mgmt_pkg::PHY_CTRL2_RST[mgmt_pkg::PC2_INT_LEVEL];
         remote_loop_ff   <= mgmt_pkg::PHY_CTRL2_RST[mgmt_pkg::PC2_REMOTE_LOOP];
      end else if (wr_fire) begin
         case (reg_addr)
            mgmt_pkg::REG_BASIC_CTRL:    basic_ctrl_ff <= wr_data;
            mgmt_pkg::REG_OP_MODE:       bcast_off_reg_ff <= wr_data[mgmt_pkg::OM_BCAST_OFF];
            mgmt_pkg::REG_INT_CTRL_STAT: int_en_ff <= wr_data[15:8];
            mgmt_pkg::REG_PHY_CTRL2: begin
               mdix_sel_ff    <= wr_data[mgmt_pkg::PC2_MDIX_SEL];
               auto_off_ff    <= wr_data[mgmt_pkg::PC2_AUTO_OFF];
               int_level_ff   <= wr_data[mgmt_pkg::PC2_INT_LEVEL];
               remote_loop_ff <= wr_data[mgmt_pkg::PC2_REMOTE_LOOP];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: an event in the clearing cycle survives
   logic st_clear;
   assign st_clear = rd_fire && (reg_addr == mgmt_pkg::REG_INT_CTRL_STAT);

   always_ff @(posedge ref_clk) begin
      if (!rst_n || sw_reset) begin
         int_st_ff <= 8'h00;
      end else begin
         int_st_ff <= (st_clear ? 8'h00 : int_st_ff)
                    | (power_down ? 8'h00 : int_event);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Functional outputs, all but pair_swap and power_down idle while powered down
   logic pd;
   logic irq_raw;
   assign pd      = basic_ctrl_ff[mgmt_pkg::BC_POWER_DOWN];
   assign irq_raw = |(int_en_ff & int_st_ff) && !pd;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         interrupt_request_out <= 1'b1;
         pair_swap             <= 1'b0;
         local_loopback        <= 1'b0;
         remote_loopback       <= 1'b0;
         power_down            <= 1'b0;
         cable_diagnostic_start <= 1'b0;
      end else begin
         interrupt_request_out <= int_level_ff ? irq_raw : ~irq_raw;
         // Zero means transmit on the first pair
         pair_swap <= auto_off_ff ? mdix_sel_ff : auto_mdix_detect;
         local_loopback <= basic_ctrl_ff[mgmt_pkg::BC_LOOPBACK]
                         && basic_ctrl_ff[mgmt_pkg::BC_FULL_DUPLEX] && !pd;
         // Forced 100 full mode or a negotiated 100 full link both qualify
         remote_loopback <= remote_loop_ff && !pd
                          && (link_100fd
                              || (basic_ctrl_ff[mgmt_pkg::BC_SPEED_100]
                                  && !basic_ctrl_ff[mgmt_pkg::BC_AN_ENABLE]
                                  && basic_ctrl_ff[mgmt_pkg::BC_FULL_DUPLEX]));
         power_down <= pd;
         cable_diagnostic_start <= wr_fire && !pd && (reg_addr == mgmt_pkg::REG_CABLE_DIAG)
                                && wr_data[mgmt_pkg::CD_START];
      end
   end

endmodule // mgmt_device

/* core/mgmt_master.sv */
`timescale 1ns/1ps
module mgmt_master (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Management link
   mgmt_if.master           mif,
   // Command port
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata
);

   ////////////////////////////////////////////////////////////////////////////
   // Line input
   logic mdio_s;

   sync2 #(.WIDTH(1)) u_sync (
      .clk (ref_clk),
      .d   (mif.mdio),
      .q   (mdio_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Frame engine
   mgmt_pkg::host_state_t state_ff;
   logic [4:0]  div_ff;
   logic        mdc_ff;
   logic [5:0]  bit_ff;
   logic [63:0] shift_ff;
   logic        is_rd_ff;
   logic        out_ff;
   logic        oe_ff;
   logic [15:0] rdata_reg_ff;
   logic        start;
   logic        is_rd;
   logic        edge_now;

   assign start    = wr && (addr == mgmt_pkg::HOST_CMD_ADDR) && (state_ff == mgmt_pkg::H_IDLE);
   assign is_rd    = wdata[mgmt_pkg::CMD_READ_BIT];
   assign edge_now = (div_ff == 5'(mgmt_pkg::MDC_HALF_CYC - 1));

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff     <= mgmt_pkg::H_IDLE;
         div_ff       <= 5'h00;
         mdc_ff       <= 1'b0;
         bit_ff       <= 6'h00;
         shift_ff     <= 64'h0;
         is_rd_ff     <= 1'b0;
         out_ff       <= 1'b1;
         oe_ff        <= 1'b0;
         rdata_reg_ff <= 16'h0000;
      end else begin
         case (state_ff)
            mgmt_pkg::H_IDLE: begin
               mdc_ff <= 1'b0;
               oe_ff  <= 1'b0;
               out_ff <= 1'b1;
               if (start) begin
                  // Preamble is all ones, so bit 63 is driven at once
                  shift_ff <= {32'hFFFFFFFF, mgmt_pkg::START_PATTERN,
                               is_rd ? mgmt_pkg::OP_READ : mgmt_pkg::OP_WRITE,
                               wdata[mgmt_pkg::CMD_PHY_LSB +: 5],
                               wdata[mgmt_pkg::CMD_REG_LSB +: 5],
                               mgmt_pkg::TA_WRITE, wdata[15:0]} << 1;
                  is_rd_ff <= is_rd;
                  out_ff   <= 1'b1;
                  oe_ff    <= 1'b1;
                  bit_ff   <= 6'h00;
                  div_ff   <= 5'h00;
                  state_ff <= mgmt_pkg::H_RUN;
               end
            end
            mgmt_pkg::H_RUN: begin
               div_ff <= edge_now ? 5'h00 : div_ff + 5'h01;
               if (edge_now) begin
                  mdc_ff <= ~mdc_ff;
                  if (!mdc_ff) begin
                     // Rising edge: both ends sample here
                     if (is_rd_ff && (bit_ff >= 6'(mgmt_pkg::DATA_FIRST_BIT))) begin
                        rdata_reg_ff <= {rdata_reg_ff[14:0], mdio_s};
                     end
                     // Wraps to zero after the last bit, which closes the frame
                     bit_ff <= bit_ff + 6'h01;
                  end else if (bit_ff == 6'h00) begin
                     // Last bit held through a full high half; releasing on the
                     // rising edge would let the pull-up reach the sampler
                     state_ff <= mgmt_pkg::H_IDLE;
                     oe_ff    <= 1'b0;
                  end else begin
                     // Falling edge: present the next bit
                     out_ff   <= shift_ff[63];
                     shift_ff <= {shift_ff[62:0], 1'b0};
                     oe_ff    <= !(is_rd_ff && (bit_ff >= 6'(mgmt_pkg::TA_FIRST_BIT)));
                  end
               end
            end
            default: state_ff <= mgmt_pkg::H_IDLE;
         endcase
      end
   end

   assign mif.mdc        = mdc_ff;
   assign mif.mdio_m_out = out_ff;
   assign mif.mdio_m_oe  = oe_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Read port: data stand one cycle only
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdata <= 32'h0;
      end else if (rd) begin
         case (addr)
            mgmt_pkg::HOST_STAT_ADDR:  rdata <= {31'h0, state_ff == mgmt_pkg::H_RUN};
            mgmt_pkg::HOST_RDATA_ADDR: rdata <= {16'h0000, rdata_reg_ff};
            default:                   rdata <= 32'h0;
         endcase
      end else begin
         rdata <= 32'h0;
      end
   end

endmodule // mgmt_master

/* core/sync2.sv */
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 1
) (
   // Clock
   input  wire logic             clk,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;

   // No reset: straps must pass through while reset is held
   always_ff @(posedge clk) begin
      meta_ff <= d;
      q       <= meta_ff;
   end
endmodule // sync2

/* shared/mgmt_if.sv */
`timescale 1ns/1ps
interface mgmt_if;
   logic mdc;
   logic mdio_m_out;
   logic mdio_m_oe;
   logic mdio_d_out;
   logic mdio_d_oe;
   logic mdio;

   // Line pulled high while nobody drives
   assign mdio = mdio_m_oe ? mdio_m_out : (mdio_d_oe ? mdio_d_out : 1'b1);

   modport master (output mdc, output mdio_m_out, output mdio_m_oe, input mdio);
   modport device (input mdc, input mdio, output mdio_d_out, output mdio_d_oe);
endinterface

/* shared/mgmt_pkg.sv */
package mgmt_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Frame layout
   localparam int          PREAMBLE_BITS  = 32;
   localparam int          CMD_BITS       = 12;
   localparam int          DATA_BITS      = 16;
   localparam int          FRAME_BITS     = 64;
   localparam int          TA_FIRST_BIT   = 46;
   localparam int          DATA_FIRST_BIT = 48;
   localparam logic [1:0]  START_PATTERN  = 2'h1;
   localparam logic [1:0]  OP_READ        = 2'h2;
   localparam logic [1:0]  OP_WRITE       = 2'h1;
   localparam logic [1:0]  TA_WRITE       = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Device register addresses
   localparam logic [4:0]  REG_BASIC_CTRL    = 5'h00;
   localparam logic [4:0]  REG_OP_MODE       = 5'h16;
   localparam logic [4:0]  REG_INT_CTRL_STAT = 5'h1B;
   localparam logic [4:0]  REG_CABLE_DIAG    = 5'h1D;
   localparam logic [4:0]  REG_PHY_CTRL2     = 5'h1F;

   // Field positions
   localparam int          BC_SOFT_RESET   = 15;
   localparam int          BC_LOOPBACK     = 14;
   localparam int          BC_SPEED_100    = 13;
   localparam int          BC_AN_ENABLE    = 12;
   localparam int          BC_POWER_DOWN   = 11;
   localparam int          BC_FULL_DUPLEX  = 8;
   localparam int          OM_BCAST_OFF    = 9;
   localparam int          IC_ENABLE_LSB   = 8;
   localparam int          PC2_MDIX_SEL    = 14;
   localparam int          PC2_AUTO_OFF    = 13;
   localparam int          PC2_INT_LEVEL   = 9;
   localparam int          PC2_REMOTE_LOOP = 2;
   localparam int          CD_START        = 15;

   // Reset values
   localparam logic [15:0] BASIC_CTRL_RST = 16'h3100;
   localparam logic [15:0] PHY_CTRL2_RST  = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Management clock made by the master
   localparam int          REF_CLK_PERIOD_PS = 5000;
   localparam int          MDC_PERIOD_NS     = 160;
   localparam int          MDC_HALF_CYC      = (MDC_PERIOD_NS * 1000) / REF_CLK_PERIOD_PS / 2;

   ////////////////////////////////////////////////////////////////////////////
   // Master command port
   localparam logic [3:0]  HOST_CMD_ADDR   = 4'h0;
   localparam logic [3:0]  HOST_STAT_ADDR  = 4'h4;
   localparam logic [3:0]  HOST_RDATA_ADDR = 4'h8;
   localparam int          CMD_READ_BIT    = 26;
   localparam int          CMD_PHY_LSB     = 21;
   localparam int          CMD_REG_LSB     = 16;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_START = 3'h1,
      ST_CMD   = 3'h3,
      ST_TA    = 3'h2,
      ST_DATA  = 3'h6
   } dev_state_t;

   typedef enum logic [1:0] {
      H_IDLE = 2'h0,
      H_RUN  = 2'h1
   } host_state_t;

endpackage

/* sim/mgmt_link_asserts.sv */
`timescale 1ns/1ps
module mgmt_link_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Link
   input wire logic mdc,
   input wire logic mdio_m_out,
   input wire logic mdio_m_oe,
   input wire logic mdio_d_out,
   input wire logic mdio_d_oe
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////
   sequence s_high_half;
      mdc [*8] ##1 mdc [*8];
   endsequence
   sequence s_preamble_start;
      (mdio_m_oe && mdio_m_out) [*8];
   endsequence

   a_no_contention: assert property (!(mdio_m_oe && mdio_d_oe))
      else $error("both ends drive the line");
   a_clock_half: assert property ($rose(mdc) |-> s_high_half ##1 !mdc)
      else $error("management clock half period wrong");
   a_master_on_fall: assert property
      (mdio_m_oe && $past(mdio_m_oe) && $changed(mdio_m_out) |-> !mdc)
      else $error("master bit changed while clock high");
   a_preamble_ones: assert property ($rose(mdio_m_oe) |-> s_preamble_start)
      else $error("frame does not open with ones");
   a_turn_zero: assert property ($rose(mdio_d_oe) |-> !mdio_d_out)
      else $error("device turnaround bit not zero");
   a_master_first: assert property ($rose(mdio_d_oe) |-> !$past(mdio_m_oe, 8))
      else $error("device drove before master released");
   a_dev_on_rise: assert property
      (mdio_d_oe && $past(mdio_d_oe) && $changed(mdio_d_out) |-> mdc)
      else $error("device bit changed while clock low");
   a_read_span: assert property ($rose(mdio_d_oe) |-> ##[540:548] $fell(mdio_d_oe))
      else $error("device drive span not seventeen bits");
endmodule // mgmt_link_asserts

/* sim/phy_mgmt_serial_ctrl_tb.sv */
`timescale 1ns/1ps
module phy_mgmt_serial_ctrl_tb;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic [7:0]  int_event = 8'h00;
   logic        mdix_det = 1'b1;
   logic        link_fd = 1'b0;
   logic        irq, swap, lloop, rloop, pdown, cd_start;
   logic [15:0] cd_pulses = 16'h0;
   logic [15:0] rv;
   int          mismatches = 0;
   int          n_tests = 0;

   mgmt_if mif ();
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (cd_start === 1'b1) cd_pulses <= cd_pulses + 16'h1;

   mgmt_master mgmt_master_inst (.ref_clk(ref_clk), .rst_n(rst_n), .mif(mif.master),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   mgmt_device mgmt_device_inst (.ref_clk(ref_clk), .rst_n(rst_n), .mif(mif.device),
      .broadcast_disable_strap(1'b0), .unique_address_strap(3'h3), .int_event(int_event),
      .interrupt_request_out(irq), .auto_mdix_detect(mdix_det), .pair_swap(swap),
      .link_100fd(link_fd), .local_loopback(lloop), .remote_loopback(rloop),
      .power_down(pdown), .cable_diagnostic_result(15'h1234),
      .cable_diagnostic_start(cd_start));
   mgmt_link_asserts mgmt_link_asserts_inst (.ref_clk(ref_clk), .rst_n(rst_n), .mdc(mif.mdc),
      .mdio_m_out(mif.mdio_m_out), .mdio_m_oe(mif.mdio_m_oe), .mdio_d_out(mif.mdio_d_out),
      .mdio_d_oe(mif.mdio_d_oe));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      rd <= r;
      wr <= ~r;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      rd <= 1'b0;
      wr <= 1'b0;
      #1;
   endtask
   // Busy poll bounded; device commits a few cycles after the last rising edge, before the master ends
   task automatic frame(input logic r, input logic [4:0] phy, input logic [4:0] rg,
                        input logic [15:0] d);
      int n;
      bus(1'b0, mgmt_pkg::HOST_CMD_ADDR, {5'h00, r, phy, rg, d});
      n = 0;
      do begin
         bus(1'b1, mgmt_pkg::HOST_STAT_ADDR, 32'h0);
         n++;
      end while (rdata[0] !== 1'b0 && n < 2000);
      if (rdata[0] !== 1'b0) mismatches++;
      repeat (12) @(posedge ref_clk);
      bus(1'b1, mgmt_pkg::HOST_RDATA_ADDR, 32'h0);
      rv = rdata[15:0];
   endtask
   task automatic pulse(input logic [7:0] ev);
      @(posedge ref_clk) int_event <= ev;
      @(posedge ref_clk) int_event <= 8'h00;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_addr();
      frame(1'b0, 5'h00, 5'h1F, 16'h4000);
      frame(1'b1, 5'h03, 5'h1F, 16'h0);
      check(rv, 16'h4000);
      frame(1'b1, 5'h05, 5'h1F, 16'h0);
      check(rv, 16'hFFFF);
      frame(1'b1, 5'h0B, 5'h1F, 16'h0);
      check(rv, 16'hFFFF);
      frame(1'b0, 5'h03, 5'h16, 16'h0200);
      frame(1'b0, 5'h00, 5'h1F, 16'h0000);
      frame(1'b1, 5'h03, 5'h1F, 16'h0);
      check(rv, 16'h4000);
   endtask
   task automatic t_cross();
      frame(1'b0, 5'h03, 5'h1F, 16'h2000);
      frame(1'b1, 5'h03, 5'h1F, 16'h0);
      check(rv, 16'h2000);
      check({15'h0, swap}, 16'h0000);
      frame(1'b0, 5'h03, 5'h1F, 16'h6000);
      check({15'h0, swap}, 16'h0001);
   endtask
   task automatic t_irq();
      frame(1'b0, 5'h03, 5'h1B, 16'h0100);
      pulse(8'h02);
      check({15'h0, irq}, 16'h0001);
      pulse(8'h01);
      check({15'h0, irq}, 16'h0000);
      frame(1'b1, 5'h03, 5'h1B, 16'h0);
      check(rv, 16'h0103);
      check({15'h0, irq}, 16'h0001);
      frame(1'b1, 5'h03, 5'h1B, 16'h0);
      check(rv, 16'h0100);
      frame(1'b0, 5'h03, 5'h1F, 16'h0200);
      check({15'h0, irq}, 16'h0000);
   endtask
   task automatic t_diag();
      frame(1'b0, 5'h03, 5'h1D, 16'h8000);
      check(cd_pulses, 16'h0001);
      frame(1'b1, 5'h03, 5'h1D, 16'h0);
      check(rv, 16'h1234);
   endtask
   task automatic t_loop();
      frame(1'b0, 5'h03, 5'h00, 16'h4100);
      check({15'h0, lloop}, 16'h0001);
      frame(1'b0, 5'h03, 5'h00, 16'h6000);
      check({15'h0, lloop}, 16'h0000);
      frame(1'b0, 5'h03, 5'h1F, 16'h0004);
      check({15'h0, rloop}, 16'h0000);
      @(posedge ref_clk) link_fd <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      check({15'h0, rloop}, 16'h0001);
      @(posedge ref_clk) link_fd <= 1'b0;
      frame(1'b0, 5'h03, 5'h00, 16'h2100);
      check({15'h0, rloop}, 16'h0001);
      frame(1'b0, 5'h03, 5'h00, 16'h2900);
      check({14'h0, rloop, pdown}, 16'h0001);
      frame(1'b1, 5'h03, 5'h00, 16'h0);
      check(rv, 16'h2900);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("Checks: %0d, mismatches: %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      check({14'h0, swap, irq}, 16'h0003);
      t_addr();
      t_cross();
      t_irq();
      t_diag();
      t_loop();
      wrap_up();
   end
   // Some 22 frames of about 2100 cycles each
   initial begin
      #400000;
      mismatches++;
      wrap_up();
   end
endmodule // phy_mgmt_serial_ctrl_tb
